//--- rtl/wake_filter_pkg.sv
package wake_filter_pkg;

    localparam int NUM_FILTERS = 4;
    localparam int FILTER_WORDS = 8;
    localparam int MASK_BITS = 31;
    localparam int DA_BYTES = 6;

    // Register byte addresses on the bus.
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_FILTER = 8'h04;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    // Fields of the wake control and status register.
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_RECEIVED_BIT = 1;
    localparam int CTRL_PME_EN_BIT = 2;
    localparam int CTRL_GLOBAL_UNI_BIT = 9;

    // Filter word order and fields inside each per-filter byte.
    localparam logic [2:0] WORD_CMD = 3'h4;
    localparam logic [2:0] WORD_OFFSET = 3'h5;
    localparam logic [2:0] WORD_CRC_LO = 3'h6;
    localparam logic [2:0] WORD_CRC_HI = 3'h7;
    localparam int CMD_ENABLE_BIT = 0;
    localparam int CMD_MCAST_BIT = 3;

    // CRC-16 generator, shifted most significant bit first.
    localparam logic [15:0] CRC_POLY = 16'h8005;
    localparam logic [15:0] CRC_INIT = 16'hffff;
    localparam logic [8:0] IDX_MAX = 9'h1ff;
    localparam logic [7:0] BROADCAST_DISABLE_BYTE = 8'hff;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_FRAME = 2'b01,
        ST_EVAL = 2'b11
    } frame_state_t;

    // One received byte from the MAC receive datapath.
    typedef struct packed {
        logic valid;
        logic first;
        logic last;
        logic addr_pass;
        logic [7:0] data;
    } rx_beat_t;

    typedef struct packed {
        logic [15:0] crc;
    } crc_state_t;

    typedef struct packed {
        logic enable;
        logic received;
        logic pme_en;
        logic global_uni;
        logic [2:0] ptr;
        logic [FILTER_WORDS-1:0][31:0] words;
        frame_state_t fstate;
        logic [8:0] idx;
        logic mcast;
        logic broadcast_disable;
        logic pass;
        logic wr_pend;
        logic rd_wait;
        logic [7:0] addr;
        logic [31:0] rdata;
    } wake_state_t;

endpackage

//--- rtl/wake_crc16.sv
`timescale 1ns/100ps
module wake_crc16
    import wake_filter_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic valid,
    input wire logic first,
    input wire logic [8:0] idx,
    input wire logic [7:0] data,
    input wire logic [MASK_BITS-1:0] mask,
    input wire logic [7:0] offset,
    output logic [15:0] crc
);

    crc_state_t s_reg, s_next;
    logic [9:0] rel;
    logic in_window;
    logic hit;

    // Folds one byte into the running remainder.
    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c;
        for (int b = 7; b >= 0; b--) begin
            r = (r[15] ^ d[b]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
        end
        return r;
    endfunction

    // Byte selection: the window opens at the offset and spans the mask.
    always_comb begin
        rel = {1'b0, idx} - {2'b00, offset};
        // R12 - offset starts window
        in_window = (idx >= {1'b0, offset}) && (rel < 10'(MASK_BITS));
        // R7 - mask bit selects byte
        hit = valid && in_window && mask[rel[4:0]];
        s_next = s_reg;
        // R20 - restart per frame
        if (valid && first) begin
            s_next.crc = hit ? crc_byte(CRC_INIT, data) : CRC_INIT;
        end else if (hit) begin
            s_next.crc = crc_byte(s_reg.crc, data);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '{crc: CRC_INIT};
        end else begin
            s_reg <= s_next;
        end
    end

    assign crc = s_reg.crc;

    property p_crc_restart;
        @(posedge clk) disable iff (!rst_n)
        valid && first && !hit |=> crc == CRC_INIT;
    endproperty
    a_crc_restart: assert property (p_crc_restart) else $error("CRC not restarted."); // R20

    property p_crc_skip;
        @(posedge clk) disable iff (!rst_n)
        !first && (!valid || !in_window) |=> $stable(crc);
    endproperty
    a_crc_skip: assert property (p_crc_skip) else $error("CRC changed outside window."); // R7

endmodule // wake_crc16

//--- rtl/wake_frame_filter.sv
// Design decisions made here: the address map and the AHB-Lite register port.
`timescale 1ns/100ps
// Contract
// R1 - enable enters detection, stops normal receive
// R2 - recognised frame raises wake event output
// R3 - recognised frame sets received status flag
// R4 - clearing enable resumes normal reception
// R5 - four filters with own fields
// R6 - wake needs address check and CRC match
// R7 - mask bit j selects byte offset+j
// R8 - host programs filters before enabling
// R9 - eight writes fill successive filter words
// R10 - command bit 3 selects multicast or unicast
// R11 - command bit 0 enables the filter
// R12 - offset byte gives first checked byte
// R13 - each filter holds expected CRC-16
// R14 - broadcast wakes despite broadcast disable
// R15 - detection works in every power state
// R16 - wake may drive the power event output
// R17 - CRC field bits 15:0 compared for match
// R18 - broadcast, global unicast, or filter pass wakes
// R19 - words: masks, command, offsets, two CRC words
// R20 - CRC restarts per frame, ends at window
module wake_frame_filter
    import wake_filter_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic RESET_N,
    input wire logic HSEL,
    input wire logic [7:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire rx_beat_t RX_BEAT,
    output logic RX_NORMAL_EN,
    output logic WAKE_EVENT,
    output logic POWER_EVENT_N
);

    logic [1:0] rst_sync_reg;
    logic rst_n;
    wake_state_t s_reg, s_next;
    logic addr_phase;
    logic wr_ctrl;
    logic wr_filter;
    logic [8:0] beat_idx;
    logic [NUM_FILTERS-1:0][15:0] crc_calc;
    logic [NUM_FILTERS-1:0] filt_hit;
    logic any_hit;

    // Reset is applied at once but released through two flops.
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rst_sync_reg <= 2'b00;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    assign addr_phase = HSEL && HTRANS[1] && HREADY;
    assign wr_ctrl = s_reg.wr_pend && (s_reg.addr == ADDR_CTRL);
    assign wr_filter = s_reg.wr_pend && (s_reg.addr == ADDR_FILTER);
    assign beat_idx = RX_BEAT.first ? 9'h000 : s_reg.idx;

    // One CRC engine and one match decision per filter.
    generate
        for (genvar i = 0; i < NUM_FILTERS; i++) begin : g_filter
            logic [7:0] cmd;
            logic [15:0] expect_crc;
            logic addr_ok;
            assign cmd = s_reg.words[WORD_CMD][8*i +: 8];
            // R13 - stored expected CRC
            // R17 - expected CRC field
            assign expect_crc = s_reg.words[WORD_CRC_LO + 3'(i / 2)][16*(i % 2) +: 16];
            // R5 - per-filter engine
            wake_crc16 u_crc (
                .clk(SYS_CLK),
                .rst_n(rst_n),
                .valid(RX_BEAT.valid && s_reg.enable),
                .first(RX_BEAT.first),
                .idx(beat_idx),
                .data(RX_BEAT.data),
                .mask(s_reg.words[i][MASK_BITS-1:0]),
                .offset(s_reg.words[WORD_OFFSET][8*i +: 8]),
                .crc(crc_calc[i])
            );
            // R14 - broadcast ignores broadcast disable
            // R18 - address cases that wake
            // R10 - address type match
            assign addr_ok = s_reg.broadcast_disable
                || (!s_reg.mcast && s_reg.global_uni)
                || (s_reg.pass && (s_reg.mcast == cmd[CMD_MCAST_BIT]));
            // R11 - filter enable
            // R6 - address check and CRC match
            assign filt_hit[i] = cmd[CMD_ENABLE_BIT] && (crc_calc[i] == expect_crc) && addr_ok;

            property p_type_gate;
                @(posedge SYS_CLK) disable iff (!rst_n)
                s_reg.fstate == ST_EVAL && filt_hit[i] && !s_reg.broadcast_disable && !s_reg.global_uni
                    |-> s_reg.mcast == cmd[CMD_MCAST_BIT];
            endproperty
            a_type_gate: assert property (p_type_gate) else $error("Wrong address type."); // R10

            property p_disabled;
                @(posedge SYS_CLK) disable iff (!rst_n)
                !cmd[CMD_ENABLE_BIT] |-> !filt_hit[i];
            endproperty
            a_disabled: assert property (p_disabled) else $error("Disabled filter hit."); // R11
        end
    endgenerate

    assign any_hit = |filt_hit;

    // Next state: bus slave, filter loading and frame tracking.
    always_comb begin
        s_next = s_reg;
        s_next.wr_pend = 1'b0;
        s_next.rd_wait = 1'b0;
        if (addr_phase) begin
            s_next.addr = HADDR;
            s_next.wr_pend = HWRITE && (HSIZE == HSIZE_WORD);
            s_next.rd_wait = !HWRITE;
        end
        // Reads wait one cycle so a write just before is always seen.
        if (s_reg.rd_wait) begin
            s_next.rdata = 32'h0000_0000;
            if (s_reg.addr == ADDR_CTRL) begin
                s_next.rdata[CTRL_ENABLE_BIT] = s_reg.enable;
                s_next.rdata[CTRL_RECEIVED_BIT] = s_reg.received;
                s_next.rdata[CTRL_PME_EN_BIT] = s_reg.pme_en;
                s_next.rdata[CTRL_GLOBAL_UNI_BIT] = s_reg.global_uni;
            end else if (s_reg.addr == ADDR_FILTER) begin
                s_next.rdata = s_reg.words[s_reg.ptr];
                s_next.ptr = s_reg.ptr + 3'h1;
            end
        end
        if (wr_ctrl) begin
            // R1 - enable detection
            // R4 - clear resumes normal
            s_next.enable = HWDATA[CTRL_ENABLE_BIT];
            s_next.pme_en = HWDATA[CTRL_PME_EN_BIT];
            s_next.global_uni = HWDATA[CTRL_GLOBAL_UNI_BIT];
            s_next.ptr = 3'h0;
            if (HWDATA[CTRL_RECEIVED_BIT]) begin
                s_next.received = 1'b0;
            end
        end
        // R9 - steer successive writes
        // R19 - fixed word order
        if (wr_filter) begin
            s_next.words[s_reg.ptr] = HWDATA;
            s_next.ptr = s_reg.ptr + 3'h1;
        end
        // R15 - no power state gating here
        case (s_reg.fstate)
            ST_IDLE: begin
                if (s_reg.enable && RX_BEAT.valid && RX_BEAT.first) begin
                    s_next.idx = 9'h001;
                    s_next.mcast = RX_BEAT.data[0];
                    s_next.broadcast_disable = RX_BEAT.data == BROADCAST_DISABLE_BYTE;
                    s_next.pass = RX_BEAT.addr_pass;
                    s_next.fstate = RX_BEAT.last ? ST_EVAL : ST_FRAME;
                end
            end
            ST_FRAME: begin
                if (RX_BEAT.valid) begin
                    if (s_reg.idx < 9'(DA_BYTES)) begin
                        s_next.broadcast_disable = s_reg.broadcast_disable && (RX_BEAT.data == BROADCAST_DISABLE_BYTE);
                    end
                    if (s_reg.idx != IDX_MAX) begin
                        s_next.idx = s_reg.idx + 9'h001;
                    end
                    s_next.pass = RX_BEAT.addr_pass;
                    if (RX_BEAT.last) begin
                        s_next.fstate = ST_EVAL;
                    end
                end
            end
            ST_EVAL: begin
                // R3 - set received flag
                if (any_hit) begin
                    s_next.received = 1'b1;
                end
                s_next.fstate = ST_IDLE;
            end
            default: begin
                s_next.fstate = ST_IDLE;
            end
        endcase
        // Looking at the next enable drops a frame in the same edge that clears it.
        if (!s_next.enable) begin
            s_next.fstate = ST_IDLE;
        end
    end

    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs other than HRESP are all taken from registered state.
    assign HRDATA = s_reg.rdata;
    assign HREADYOUT = !s_reg.rd_wait;
    assign HRESP = 1'b0;
    assign RX_NORMAL_EN = !s_reg.enable;
    // R2 - wake event level
    assign WAKE_EVENT = s_reg.received;
    // R16 - power event path
    assign POWER_EVENT_N = !(s_reg.received && s_reg.pme_en);

    property p_enter_mode;
        @(posedge SYS_CLK) disable iff (!rst_n)
        wr_ctrl && HWDATA[CTRL_ENABLE_BIT] |=> !RX_NORMAL_EN;
    endproperty
    a_enter_mode: assert property (p_enter_mode) else $error("Normal receive not stopped."); // R1

    property p_leave_mode;
        @(posedge SYS_CLK) disable iff (!rst_n)
        wr_ctrl && !HWDATA[CTRL_ENABLE_BIT] |=> RX_NORMAL_EN && s_reg.fstate == ST_IDLE;
    endproperty
    a_leave_mode: assert property (p_leave_mode) else $error("Normal receive not resumed."); // R4

    property p_flag_set;
        @(posedge SYS_CLK) disable iff (!rst_n)
        s_reg.fstate == ST_EVAL && any_hit |=> s_reg.received;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("Received flag not set on match."); // R3

    property p_wake_cause;
        @(posedge SYS_CLK) disable iff (!rst_n)
        $rose(WAKE_EVENT) |-> $past(s_reg.fstate) == ST_EVAL && $past(any_hit);
    endproperty
    a_wake_cause: assert property (p_wake_cause) else $error("Wake event without a match."); // R2

    property p_broadcast_disable_wake;
        @(posedge SYS_CLK) disable iff (!rst_n)
        s_reg.fstate == ST_EVAL && s_reg.broadcast_disable && filt_hit[0] |=> WAKE_EVENT;
    endproperty
    a_broadcast_disable_wake: assert property (p_broadcast_disable_wake) else $error("Broadcast did not wake."); // R14

    property p_ptr_step;
        @(posedge SYS_CLK) disable iff (!rst_n)
        wr_filter |=> s_reg.ptr == $past(s_reg.ptr) + 3'h1;
    endproperty
    a_ptr_step: assert property (p_ptr_step) else $error("Filter pointer did not advance."); // R9

    property p_cmd_word;
        @(posedge SYS_CLK) disable iff (!rst_n)
        wr_filter && s_reg.ptr == WORD_CMD |=> s_reg.words[WORD_CMD] == $past(HWDATA);
    endproperty
    a_cmd_word: assert property (p_cmd_word) else $error("Command word not written."); // R19

    property p_pme;
        @(posedge SYS_CLK) disable iff (!rst_n)
        !POWER_EVENT_N |-> WAKE_EVENT && s_reg.pme_en;
    endproperty
    a_pme: assert property (p_pme) else $error("Power event without enabled wake."); // R16

    c_wake: cover property (@(posedge SYS_CLK) disable iff (!rst_n) $rose(WAKE_EVENT));
    c_load: cover property (@(posedge SYS_CLK) disable iff (!rst_n)
        wr_filter && s_reg.ptr == WORD_CRC_HI);
    c_read: cover property (@(posedge SYS_CLK) disable iff (!rst_n) s_reg.rd_wait ##1 HREADYOUT);

endmodule // wake_frame_filter

//--- verification/wake_rx_model.sv
`timescale 1ns/100ps
// Receive datapath stand-in: one byte a cycle, back to back, first and last marked.
module wake_rx_model
    import wake_filter_pkg::*;
(
    input wire logic clk,
    output rx_beat_t beat
);
    initial beat = '0;

    // Between frames the byte lane shows the inverted last byte, never a stale copy.
    task automatic send(input logic [7:0] b[64], input int n, input logic ap);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            beat <= '{1'b1, i == 0, i == n - 1, ap, b[i]};
        end
        @(posedge clk);
        beat <= '{1'b0, 1'b0, 1'b0, ~ap, ~b[n - 1]};
    endtask
endmodule // wake_rx_model

//--- verification/tb_wake_frame_filter.sv
`timescale 1ns/100ps
module tb_wake_frame_filter
    import wake_filter_pkg::*;
;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic hsel = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic rx_normal_en;
    logic wake_event;
    logic power_event_n;
    rx_beat_t beat;
    logic [7:0] fr[64];
    logic [31:0] fw[8];
    logic [31:0] x;
    logic [31:0] ctl;
    logic gu, pm, ap, w;
    int n_fail = 0;
    int n_tests = 0;
    int cyc = 0;
    int len, kind, tgt;

    always #25 sys_clk = ~sys_clk;

    wake_frame_filter u_dut (
        .SYS_CLK(sys_clk), .RESET_N(reset_n), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
        .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
        .RX_BEAT(beat), .RX_NORMAL_EN(rx_normal_en), .WAKE_EVENT(wake_event),
        .POWER_EVENT_N(power_event_n)
    );

    wake_rx_model u_rx (.clk(sys_clk), .beat(beat));

    task automatic end_sim();
        $display("tests=%0d fails=%0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One single transfer; the address phase holds until ready, then the data phase.
    task automatic xfer(input logic [7:0] a, input logic wr, input logic [31:0] d,
                        input logic [2:0] sz, output logic [31:0] rd);
        @(posedge sys_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        hsize <= sz;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        xfer(a, 1'b1, d, HSIZE_WORD, dummy);
    endtask

    // Reference CRC over the masked window, most significant bit of each byte first.
    function automatic logic [15:0] bench_crc(logic [31:0] m, int off, int n);
        logic [15:0] c;
        c = CRC_INIT;
        for (int j = 0; j < MASK_BITS; j++)
            if (m[j] && off + j < n)
                for (int b = 7; b >= 0; b--)
                    c = {c[14:0], 1'b0} ^ ((c[15] ^ fr[off + j][b]) ? CRC_POLY : 16'h0);
        return c;
    endfunction

    // Wake verdict over all four filters from their fields and the frame's address.
    function automatic logic wake_exp(int n, logic g, logic p);
        logic r, bc, mc;
        logic [7:0] c;
        r = 1'b0;
        bc = 1'b1;
        mc = fr[0][0];
        for (int i = 0; i < DA_BYTES; i++)
            if (fr[i] != BROADCAST_DISABLE_BYTE) bc = 1'b0;
        for (int f = 0; f < NUM_FILTERS; f++) begin
            c = fw[WORD_CMD][8 * f +: 8];
            if (c[CMD_ENABLE_BIT] && bench_crc(fw[f], fw[WORD_OFFSET][8 * f +: 8], n)
                == fw[6 + f / 2][16 * (f % 2) +: 16]
                && (bc || (!mc && g) || (p && mc == c[CMD_MCAST_BIT])))
                r = 1'b1;
        end
        return r;
    endfunction

    // The ceiling is several times the expected run length.
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            end_sim();
        end
    end

    initial begin
        void'($urandom(45));
        repeat (2) @(posedge sys_clk);
        chk({hreadyout, wake_event, rx_normal_en, power_event_n}, 32'hb);
        reset_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        for (int t = 0; t < 30; t++) begin
            len = 14 + $urandom % 30;
            kind = $urandom % 3;
            foreach (fr[i]) fr[i] = 8'($urandom);
            if (kind == 0)
                for (int i = 0; i < DA_BYTES; i++) fr[i] = BROADCAST_DISABLE_BYTE;
            else begin
                fr[0][0] = (kind == 1);
                fr[1] = 8'h00;
            end
            foreach (fw[i]) fw[i] = $urandom;
            for (int i = 0; i < NUM_FILTERS; i++) fw[WORD_OFFSET][8 * i +: 8] = 8'($urandom % 16);
            tgt = $urandom % 4;
            if (t < 4) fw[WORD_CMD][8 * tgt] = 1'b1;
            // Plant a true CRC in most trials so that matches really happen.
            if (t % 4 != 3)
                fw[6 + tgt / 2][16 * (tgt % 2) +: 16] =
                    bench_crc(fw[tgt], fw[WORD_OFFSET][8 * tgt +: 8], len);
            gu = 1'($urandom);
            pm = 1'($urandom);
            ap = 1'($urandom);
            wr(ADDR_CTRL, 32'h2);
            repeat (2) @(posedge sys_clk);
            chk(rx_normal_en, 32'h1);
            for (int i = 0; i < FILTER_WORDS; i++) wr(ADDR_FILTER, fw[i]);
            if (t == 0) begin
                wr(ADDR_CTRL, 32'h0);
                for (int i = 0; i < FILTER_WORDS; i++) begin
                    xfer(ADDR_FILTER, 1'b0, 32'h0, HSIZE_WORD, x);
                    chk(x, fw[i]);
                end
            end
            ctl = (32'(gu) << CTRL_GLOBAL_UNI_BIT) | (32'(pm) << CTRL_PME_EN_BIT) | 32'h1;
            wr(ADDR_CTRL, ctl);
            repeat (2) @(posedge sys_clk);
            chk(rx_normal_en, 32'h0);
            u_rx.send(fr, len, ap);
            repeat (4) @(posedge sys_clk);
            w = wake_exp(len, gu, ap);
            chk(wake_event, w);
            chk(power_event_n, !(w && pm));
            xfer(ADDR_CTRL, 1'b0, 32'h0, HSIZE_WORD, x);
            chk(x, ctl | (32'(w) << CTRL_RECEIVED_BIT));
        end
        // Frames are not examined once detection is switched off.
        wr(ADDR_CTRL, 32'h2);
        u_rx.send(fr, len, 1'b1);
        repeat (4) @(posedge sys_clk);
        chk(wake_event, 32'h0);
        // Unmapped place and a byte-sized write are both ignored.
        wr(8'h08, 32'hffffffff);
        xfer(8'h08, 1'b0, 32'h0, HSIZE_WORD, x);
        chk(x, 32'h0);
        xfer(ADDR_CTRL, 1'b1, 32'h1, 3'h0, x);
        xfer(ADDR_CTRL, 1'b0, 32'h0, HSIZE_WORD, x);
        chk(x, 32'h0);
        chk(hresp, 32'h0);
        end_sim();
    end
endmodule // tb_wake_frame_filter
